// >>> design/servo_cmd_pkg.sv
// Constants for the servo command conditioning and brake sequencer.
// Assumes one 40 MHz clock; all settings arrive as plain ports.
package servo_cmd_pkg;
  // ********************************************
  // Widths and timing
  // ********************************************
  localparam int CMD_W          = 16;
  localparam int GAIN_W         = 16;
  localparam int GAIN_FRAC      = 8;
  localparam int TMR_W          = 16;
  localparam int CLK_HZ         = 40_000_000;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = (CLK_HZ / 1_000_000) * TICK_US;
  localparam logic [CMD_W-1:0] CMD_RESET = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_RESET = 16'h0000;

  // ********************************************
  // Sequencer states
  // ********************************************
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_DECEL  = 2'b01,
    ST_DELAY  = 2'b11,
    ST_OFF    = 2'b10
  } seq_state_t;
endpackage

// >>> design/servo_command_brake_sequencer.sv
// Servo command conditioning and brake/stop sequencer.
// Assumes the analog command arrives as a signed sample synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module servo_command_brake_sequencer #(
  parameter int TICK_CYCLES = servo_cmd_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                                     clk,
  input  wire logic                                     rst_n,
  // Analog command path
  input  wire logic signed [servo_cmd_pkg::CMD_W-1:0]   analog_cmd,
  input  wire logic signed [servo_cmd_pkg::CMD_W-1:0]   signal_offset,
  input  wire logic        [servo_cmd_pkg::CMD_W-1:0]   dead_band,
  input  wire logic        [servo_cmd_pkg::GAIN_W-1:0]  signal_gain,
  output logic signed      [servo_cmd_pkg::CMD_W-1:0]   current_cmd,
  // Velocity feedback
  input  wire logic signed [servo_cmd_pkg::CMD_W-1:0]   vel_raw,
  input  wire logic                                     tach_reverse,
  output logic signed      [servo_cmd_pkg::CMD_W-1:0]   vel_meas,
  // Mode and brake settings
  input  wire logic                                     drive_enable,
  input  wire logic                                     velocity_mode,
  input  wire logic                                     braking_enable,
  input  wire logic                                     brake_switch_polarity,
  input  wire logic        [servo_cmd_pkg::CMD_W-1:0]   brake_decel,
  input  wire logic        [servo_cmd_pkg::CMD_W-1:0]   zero_speed_window,
  input  wire logic        [servo_cmd_pkg::TMR_W-1:0]   max_decel_time,
  input  wire logic        [servo_cmd_pkg::TMR_W-1:0]   pwm_disable_delay,
  input  wire logic signed [servo_cmd_pkg::CMD_W-1:0]   vel_cmd_in,
  // Drive outputs
  output logic signed      [servo_cmd_pkg::CMD_W-1:0]   vel_cmd,
  output logic                                          pwm_enable,
  output logic                                          brake_engaged,
  output logic                                          brake_switch,
  output logic                                          decelerating
);
  import servo_cmd_pkg::*;

  // ********************************************
  // Command conditioning
  // ********************************************
  logic signed [CMD_W:0]          sum_w;
  logic signed [CMD_W-1:0]        off_w;
  logic        [CMD_W-1:0]        mag_w;
  logic signed [CMD_W-1:0]        db_w;
  logic signed [CMD_W+GAIN_W:0]   prod_w;
  logic signed [CMD_W+GAIN_W:0]   shf_w;
  logic signed [CMD_W-1:0]        scaled_w;
  localparam logic signed [CMD_W+GAIN_W:0] SMAX = 33'sh7FFF;
  localparam logic signed [CMD_W+GAIN_W:0] SMIN = -33'sh8000;

  assign sum_w  = CMD_W'(0) + {analog_cmd[CMD_W-1], analog_cmd}
                + {signal_offset[CMD_W-1], signal_offset};
  assign off_w  = (sum_w > 17'sh7FFF) ? 16'sh7FFF :
                  (sum_w < -17'sh8000) ? -16'sh8000 : sum_w[CMD_W-1:0];
  assign mag_w  = off_w[CMD_W-1] ? CMD_W'(-off_w) : off_w;
  assign db_w   = (mag_w < dead_band) ? 16'sh0000 : off_w;
  assign prod_w = (CMD_W+GAIN_W+1)'(db_w * $signed({1'b0, signal_gain}));
  assign shf_w  = prod_w >>> GAIN_FRAC;
  assign scaled_w = (shf_w > SMAX) ? 16'sh7FFF :
                    (shf_w < SMIN) ? -16'sh8000 : shf_w[CMD_W-1:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      current_cmd <= CMD_RESET;
      vel_meas    <= CMD_RESET;
    end else begin
      current_cmd <= pwm_enable ? scaled_w : CMD_RESET;
      vel_meas    <= tach_reverse ? CMD_W'(-vel_raw) : vel_raw;
    end
  end

  // ********************************************
  // Tick divider
  // ********************************************
  logic [31:0] div_reg;
  logic        tick_w;
  assign tick_w = (div_reg == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (!rst_n || tick_w)
      div_reg <= 32'h00000000;
    else
      div_reg <= div_reg + 32'h00000001;
  end

  // ********************************************
  // Brake/stop sequencer
  // ********************************************
  seq_state_t        state_reg, state_next;
  logic [TMR_W-1:0]  tmr_reg;
  logic              disable_req_w, in_window_w, decel_done_w, delay_done_w;
  logic [CMD_W-1:0]  vmag_w;

  assign disable_req_w = !drive_enable;
  assign vmag_w        = vel_meas[CMD_W-1] ? CMD_W'(-vel_meas) : vel_meas;
  assign in_window_w   = (vmag_w <= zero_speed_window);
  assign decel_done_w  = (tmr_reg >= max_decel_time);
  assign delay_done_w  = (tmr_reg >= pwm_disable_delay);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (disable_req_w) begin
          if (!braking_enable || !velocity_mode)
            state_next = ST_OFF;
          else if (max_decel_time == TMR_RESET)
            state_next = ST_DELAY;
          else
            state_next = ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (drive_enable)
          state_next = ST_RUN;
        else if (in_window_w || decel_done_w)
          state_next = ST_DELAY;
      end
      ST_DELAY: begin
        if (drive_enable)
          state_next = ST_RUN;
        else if (delay_done_w)
          state_next = ST_OFF;
      end
      ST_OFF: begin
        if (drive_enable)
          state_next = ST_RUN;
      end
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_OFF;
      tmr_reg   <= TMR_RESET;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || drive_enable)
        tmr_reg <= TMR_RESET;
      else if (tick_w && tmr_reg != {TMR_W{1'b1}})
        tmr_reg <= tmr_reg + TMR_W'(1);
    end
  end

  // Velocity command ramp toward zero during deceleration
  logic signed [CMD_W:0] ramp_w;
  assign ramp_w = vel_cmd[CMD_W-1] ? (CMD_W+1)'(vel_cmd + $signed({1'b0, brake_decel}))
                                   : (CMD_W+1)'(vel_cmd - $signed({1'b0, brake_decel}));
  always_ff @(posedge clk) begin
    if (!rst_n)
      vel_cmd <= CMD_RESET;
    else if (state_reg == ST_RUN)
      vel_cmd <= vel_cmd_in;
    else if (state_reg == ST_DECEL && tick_w) begin
      if (vel_cmd[CMD_W-1] ? ramp_w >= 0 : ramp_w <= 0)
        vel_cmd <= CMD_RESET;
      else
        vel_cmd <= ramp_w[CMD_W-1:0];
    end else if (state_reg != ST_DECEL)
      vel_cmd <= CMD_RESET;
  end

  // ********************************************
  // Outputs
  // ********************************************
  // Velocity stop with braking enabled keeps power on through the disable cycle
  logic run_hold_w;
  logic powered_run_w;
  assign run_hold_w    = drive_enable || (velocity_mode && braking_enable);
  assign powered_run_w = (state_reg == ST_RUN && run_hold_w) || (state_reg == ST_DECEL);
  assign decelerating  = (state_reg == ST_DECEL);
  assign pwm_enable    = powered_run_w || (state_reg == ST_DELAY);
  assign brake_engaged = braking_enable && !powered_run_w;
  assign brake_switch  = brake_switch_polarity ? brake_engaged : !brake_engaged;

  // ********************************************
  // Checks
  // ********************************************
  property p_cur_brake;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_RUN && !drive_enable && braking_enable && !velocity_mode)
        |-> (!pwm_enable && brake_engaged);
  endproperty
  a_cur_brake: assert property (p_cur_brake) else $error("brake not immediate");

  property p_seq_hold;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_RUN && !drive_enable && velocity_mode && braking_enable)
        |-> (pwm_enable && !brake_engaged);
  endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("power dropped at stop start");

  property p_seq_start;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_RUN && !drive_enable && velocity_mode && braking_enable
       && max_decel_time != 16'h0000) |=> decelerating;
  endproperty
  a_seq_start: assert property (p_seq_start) else $error("no decel start");

  property p_zero_decel;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_RUN && !drive_enable && velocity_mode && braking_enable
       && max_decel_time == 16'h0000) |=> (brake_engaged && !decelerating);
  endproperty
  a_zero_decel: assert property (p_zero_decel) else $error("decel phase ran");

  property p_win;
    @(posedge clk) disable iff (!rst_n)
      (decelerating && !drive_enable && in_window_w) |=> (brake_engaged && pwm_enable);
  endproperty
  a_win: assert property (p_win) else $error("window missed");

  property p_delay;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == ST_DELAY && !drive_enable && delay_done_w) |=> !pwm_enable;
  endproperty
  a_delay: assert property (p_delay) else $error("pwm not off");

  property p_pol;
    @(posedge clk) disable iff (!rst_n)
      brake_engaged |-> (brake_switch == brake_switch_polarity);
  endproperty
  a_pol: assert property (p_pol) else $error("brake polarity");

  property p_tach;
    @(posedge clk) disable iff (!rst_n)
      tach_reverse |=> (vel_meas == CMD_W'(-$past(vel_raw)));
  endproperty
  a_tach: assert property (p_tach) else $error("tach sign");

  property p_db;
    @(posedge clk) disable iff (!rst_n)
      (mag_w < dead_band) |=> (current_cmd == 16'sh0000);
  endproperty
  a_db: assert property (p_db) else $error("dead band leak");

  property p_clr;
    @(posedge clk) disable iff (!rst_n)
      drive_enable |=> (tmr_reg == 16'h0000);
  endproperty
  a_clr: assert property (p_clr) else $error("timer not cleared");

  property p_gain;
    @(posedge clk) disable iff (!rst_n)
      pwm_enable |=> (current_cmd == $past(scaled_w));
  endproperty
  a_gain: assert property (p_gain) else $error("gain path");
endmodule // servo_command_brake_sequencer
`default_nettype wire

// >>> tb/motor_brake_model.sv
// Motor with tach and holding brake on the drive's far side.
// Assumes it is clocked with the sequencer it faces.
`timescale 1ns/1ps
`default_nettype none
module motor_brake_model
  import servo_cmd_pkg::*;
(
  // Drive side
  input  wire logic                    clk,
  input  wire logic                    pwm_enable,
  input  wire logic signed [CMD_W-1:0] vel_cmd,
  input  wire logic                    brake_switch,
  input  wire logic                    power_on_brake,
  input  wire logic                    wired_backwards,
  // Sensor side
  output logic signed      [CMD_W-1:0] vel_raw,
  output logic                         brake_held
);
  logic signed [CMD_W-1:0] speed_reg = '0;
  wire logic signed [CMD_W-1:0] target = pwm_enable ? vel_cmd : '0;
  wire logic signed [CMD_W:0]   diff   = target - speed_reg;
  // Speed slews 16 per cycle, coasts to rest without power
  always_ff @(posedge clk) begin
    if (diff > 17'sh00010) speed_reg <= speed_reg + 16'sh0010;
    else if (diff < -17'sh00010) speed_reg <= speed_reg - 16'sh0010;
    else speed_reg <= target;
  end
  assign vel_raw    = wired_backwards ? -speed_reg : speed_reg;
  assign brake_held = (brake_switch == power_on_brake);
endmodule // motor_brake_model
`default_nettype wire

// >>> tb/test_servo_command_brake_sequencer.sv
// Self-checking bench for the command conditioner and brake sequencer.
// Assumes a 4-cycle tick so timer figures are short.
`timescale 1ns/1ps
`default_nettype none
module test_servo_command_brake_sequencer;
  import servo_cmd_pkg::*;
  localparam int T = 4;
  typedef struct {logic [15:0] a, o, d, g, e;} row_t;
  row_t rows [6] = '{'{16'h0100, 16'h0000, 16'h0000, 16'h0100, 16'h0100},
    '{16'h0100, 16'h0010, 16'h0000, 16'h0200, 16'h0220},
    '{16'h0009, 16'h0000, 16'h000A, 16'h0100, 16'h0000},
    '{16'h000A, 16'h0000, 16'h000A, 16'h0100, 16'h000A},
    '{16'hFFF0, 16'h0000, 16'h000A, 16'h0080, 16'hFFF8},
    '{16'h7000, 16'h0000, 16'h0000, 16'h0400, 16'h7FFF}};
  logic clk = 0, rst_n = 0, tach_reverse = 0, drive_enable = 0, velocity_mode = 0;
  logic braking_enable = 1, brake_switch_polarity = 0, wired_backwards = 0;
  logic signed [15:0] analog_cmd = 0, signal_offset = 0, vel_cmd_in = 0, v0;
  logic [15:0] dead_band = 0, signal_gain = 0, brake_decel = 0, zero_speed_window = 0;
  logic [15:0] max_decel_time = 0, pwm_disable_delay = 0;
  wire logic signed [15:0] current_cmd, vel_raw, vel_meas, vel_cmd;
  wire logic pwm_enable, brake_engaged, brake_switch, decelerating, brake_held;
  int fail_count = 0, n_compared = 0, n;
  always #12.5 clk = ~clk;
  servo_command_brake_sequencer #(.TICK_CYCLES(T)) i_servo_command_brake_sequencer (
    .clk(clk), .rst_n(rst_n), .analog_cmd(analog_cmd), .signal_offset(signal_offset),
    .dead_band(dead_band), .signal_gain(signal_gain), .current_cmd(current_cmd),
    .vel_raw(vel_raw), .tach_reverse(tach_reverse), .vel_meas(vel_meas),
    .drive_enable(drive_enable), .velocity_mode(velocity_mode),
    .braking_enable(braking_enable), .brake_switch_polarity(brake_switch_polarity),
    .brake_decel(brake_decel), .zero_speed_window(zero_speed_window),
    .max_decel_time(max_decel_time), .pwm_disable_delay(pwm_disable_delay),
    .vel_cmd_in(vel_cmd_in), .vel_cmd(vel_cmd), .pwm_enable(pwm_enable),
    .brake_engaged(brake_engaged), .brake_switch(brake_switch), .decelerating(decelerating));
  motor_brake_model i_motor_brake_model (.clk(clk), .pwm_enable(pwm_enable),
    .vel_cmd(vel_cmd), .brake_switch(brake_switch), .power_on_brake(brake_switch_polarity),
    .wired_backwards(wired_backwards), .vel_raw(vel_raw), .brake_held(brake_held));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Counts cycles while the state output stays high, bounded
  task automatic span(input logic sel_pwm);
    n = 0;
    while (((sel_pwm ? pwm_enable : decelerating) === 1'b1) && n < 2000) begin
      cyc(1);
      n++;
    end
    if (n >= 2000) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, n, 2000);
      fail_count++;
    end
  endtask
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    fail_count++;
    final_report();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cyc(4);
    rst_n = 1;
    check(pwm_enable, 0);
    check(brake_engaged, 1);
    $display("reset done");
    drive_enable = 1;
    for (int i = 0; i < 6; i++) begin
      {analog_cmd, signal_offset, dead_band, signal_gain} = {rows[i].a, rows[i].o, rows[i].d, rows[i].g};
      cyc(3);
      check(current_cmd, rows[i].e);
    end
    $display("gain table done");
    velocity_mode = 1; vel_cmd_in = 16'sh0040; wired_backwards = 1; tach_reverse = 1;
    cyc(10);
    check(vel_meas, 16'h0040);
    tach_reverse = 0;
    cyc(2);
    check(vel_meas, 16'hFFC0);
    tach_reverse = 1;
    $display("tach sign done");
    max_decel_time = 3; pwm_disable_delay = 2; brake_decel = 4; zero_speed_window = 2;
    for (int k = 0; k < 2; k++) begin
      drive_enable = 0;
      #1;
      check({pwm_enable, brake_engaged}, 16'h0002);
      cyc(1);
      check(decelerating, 1);
      check(brake_engaged, 0);
      if (k == 0) begin
        cyc(5);
        drive_enable = 1;
        cyc(2);
        check(brake_engaged, 0);
        drive_enable = 0;
        cyc(1);
      end
      span(0);
      check(16'(n >= 2 * T - 1 && n <= 4 * T + 2), 1);
      check(brake_engaged, 1);
      check(pwm_enable, 1);
      check(brake_switch, 0);
      span(1);
      check(16'(n >= T - 1 && n <= 3 * T + 2), 1);
      cyc(2);
      check(current_cmd, 0);
      drive_enable = 1;
      cyc(20);
    end
    $display("timeout stop done");
    max_decel_time = 16'h0100; brake_decel = 16'h0010; vel_cmd_in = 16'sh0020;
    cyc(10);
    drive_enable = 0;
    cyc(1);
    v0 = vel_cmd;
    cyc(T + 2);
    check(16'(vel_cmd < v0), 1);
    span(0);
    check(16'(n < 10 * T), 1);
    check(brake_engaged, 1);
    span(1);
    drive_enable = 1;
    max_decel_time = 0;
    cyc(20);
    drive_enable = 0;
    cyc(2);
    check({decelerating, brake_engaged, pwm_enable}, 16'h0003);
    span(1);
    braking_enable = 0;
    drive_enable = 1;
    cyc(20);
    drive_enable = 0;
    cyc(2);
    check({decelerating, brake_engaged, pwm_enable}, 16'h0000);
    $display("stop variants done");
    velocity_mode = 0; braking_enable = 1; brake_switch_polarity = 1; drive_enable = 1;
    cyc(4);
    drive_enable = 0;
    #1;
    check({pwm_enable, brake_engaged, brake_switch, brake_held}, 16'h0007);
    cyc(2);
    check({pwm_enable, brake_switch}, 16'h0001);
    $display("current mode brake done");
    velocity_mode = 1; brake_switch_polarity = 0; max_decel_time = 16'h0100; drive_enable = 1;
    cyc(10);
    drive_enable = 0;
    cyc(2);
    check(decelerating, 1);
    rst_n = 0;
    cyc(2);
    check({decelerating, pwm_enable, brake_engaged}, 16'h0001);
    check(vel_cmd, 0);
    check(current_cmd, 0);
    check(vel_meas, 0);
    rst_n = 1;
    cyc(2);
    check({decelerating, pwm_enable, brake_engaged}, 16'h0001);
    drive_enable = 1;
    cyc(2);
    check({decelerating, pwm_enable, brake_engaged}, 16'h0002);
    $display("mid-run reset done");
    final_report();
  end
endmodule // test_servo_command_brake_sequencer
`default_nettype wire
